//--- hw/gms_pkg.sv
// Constants, register map and field layout of the GPIO mode, strobe and PWM controller
package gms_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 1_024_000;
  localparam int TICK_INC = TICK_HZ / 1000;
  localparam int TICK_MOD = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int DEF_FILTER_CYC = 16;
  localparam int NUM_LINES = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] GLOBAL_CTRL = 16'h1100;
  localparam logic [15:0] STROBE_TIME = 16'h1104;
  localparam logic [15:0] STROBE_PAT = 16'h1108;
  localparam logic [15:0] LINE_STATUS = 16'h110C;
  localparam logic [15:0] PIN_CTRL_BASE = 16'h1110;
  localparam logic [15:0] PIN_XTRA_BASE = 16'h1114;
  localparam logic [15:0] PIN_STRIDE = 16'h0010;
  localparam logic [15:0] PWM_TIME = 16'h1150;
  localparam logic [15:0] PWM_CTRL = 16'h1154;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FN_LSB = 0;
  localparam int FLIP_BIT = 3;
  localparam int SRC_LSB = 4;
  localparam int USER_BIT = 6;
  localparam int STROBE_ON_BIT = 7;
  localparam int DBNC_EN_BIT = 8;
  localparam int EXT_TRIG_BIT = 0;
  localparam int LINE_PICK_LSB = 8;
  localparam int PAT_PERIOD_LSB = 16;
  localparam int GATE_EN_BIT = 16;
  localparam int GATE_LINE_LSB = 17;
  localparam int GATE_LEVEL_BIT = 19;
  localparam int PWM_RUN_BIT = 20;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] FN_INPUT = 3'h0;
  localparam logic [2:0] FN_OUTPUT = 3'h1;
  localparam logic [2:0] FN_TRIGGER = 3'h2;
  localparam logic [2:0] FN_STROBE = 3'h3;
  localparam logic [2:0] FN_PWM = 3'h4;
  localparam logic [2:0] FN_LAST = 3'h4;
  localparam logic [1:0] SRC_EXPOSURE = 2'h0;
  localparam logic [1:0] SRC_TRIGGER = 2'h1;
  localparam logic [1:0] SRC_USER = 2'h2;
  // Line 0 input only, line 1 output only, lines 2 and 3 both ways
  localparam logic [3:0][4:0] FN_ALLOWED = {5'h1F, 5'h1F, 5'h1A, 5'h05};
  localparam logic [3:0][31:0] PIN_CTRL_RST = {32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0002};
  localparam logic [31:0] PIN_XTRA_RST = 32'h0000_0000;
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
  localparam logic [31:0] STROBE_TIME_RST = 32'h0000_0000;
  localparam logic [31:0] STROBE_PAT_RST = 32'h0000_FFFF;
  localparam logic [31:0] PWM_TIME_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} gms_strobe_state_type;
  typedef enum logic [1:0] {PW_IDLE, PW_HIGH, PW_LOW} gms_pwm_state_type;

endpackage

//--- hw/gms_gpio_ctrl.sv
// Four-line GPIO controller: line modes, input filter, strobe engine and shared PWM source
//
// Added by the designer: strobed register access.
module gms_gpio_ctrl (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic [gms_pkg::NUM_LINES-1:0] i_line_in,
  output logic [gms_pkg::NUM_LINES-1:0] o_line_out,
  output logic [gms_pkg::NUM_LINES-1:0] o_line_oe,
  input wire logic i_exposure_active,
  output logic o_trigger,
  output logic o_trigger_active,
  output logic o_stream_stop
);
  import gms_pkg::*;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------
  // Registers and shared state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q [NUM_LINES];
  logic [31:0] xtra_q [NUM_LINES];
  logic [31:0] global_q;
  logic [31:0] strobe_time_q;
  logic [31:0] strobe_pat_q;
  logic [31:0] pwm_time_q;
  logic [31:0] pwm_ctrl_q;
  logic [NUM_LINES-1:0] line_val;
  logic [NUM_LINES-1:0] trig_hit;
  logic [NUM_LINES-1:0] trig_line;
  logic [NUM_LINES-1:0] out_d;
  logic [NUM_LINES-1:0] oe_d;
  logic ext_trig;
  logic trig_any;
  logic exp_q;
  logic exp_start;
  logic exp_end;
  logic [16:0] acc_q;
  logic tick_q;
  gms_strobe_state_type st_q;
  logic [15:0] st_cnt_q;
  logic [3:0] frame_q;
  logic strobe_q;
  logic dur_exp_q;
  logic seen_exp_q;
  logic ref_evt;
  logic fire;
  gms_pwm_state_type pw_q;
  logic [15:0] pw_cnt_q;
  logic [15:0] pw_left_q;
  logic pwm_level_q;
  logic gate_ok;
  logic pwm_start;
  logic pwm_stop;
  logic [31:0] rd_d;

  assign ext_trig = global_q[EXT_TRIG_BIT];
  assign trig_any = |trig_hit;
  assign exp_start = i_exposure_active & ~exp_q;
  assign exp_end = ~i_exposure_active & exp_q;

  // ----------------------------------------------------------------
  // Per-line configuration, input filter and output select
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < NUM_LINES; gi++) begin : g_line
    localparam logic [15:0] CTRL_ADDR = 16'(PIN_CTRL_BASE + gi * PIN_STRIDE);
    localparam logic [15:0] XTRA_ADDR = 16'(PIN_XTRA_BASE + gi * PIN_STRIDE);
    logic [2:0] sync_q;
    logic level_q;
    logic val_prev_q;
    logic [23:0] flt_cnt_q;
    logic [23:0] limit;
    logic [2:0] fn;
    logic [1:0] src;
    logic flip;
    logic src_val;

    assign fn = ctrl_q[gi][FN_LSB +: 3];
    assign src = ctrl_q[gi][SRC_LSB +: 2];
    assign flip = ctrl_q[gi][FLIP_BIT];

    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        ctrl_q[gi] <= PIN_CTRL_RST[gi];
        xtra_q[gi] <= PIN_XTRA_RST;
      end else if (i_wr_en && i_addr == CTRL_ADDR) begin
        // A mode the line cannot take is refused and the old mode kept
        if (i_wr_data[2:0] <= FN_LAST && FN_ALLOWED[gi][i_wr_data[2:0]]) begin
          ctrl_q[gi] <= i_wr_data;
        end else begin
          ctrl_q[gi] <= {i_wr_data[31:3], ctrl_q[gi][2:0]};
        end
      end else if (i_wr_en && i_addr == XTRA_ADDR) begin
        xtra_q[gi] <= {16'h0000, i_wr_data[15:0]};
      end
    end

    // Pin is asynchronous: three stages, a change counts when stages two and three agree
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        sync_q <= 3'h0;
      end else begin
        sync_q <= {sync_q[1], sync_q[0], i_line_in[gi]};
      end
    end

    always_comb begin
      if (fn == FN_INPUT && ctrl_q[gi][DBNC_EN_BIT] && xtra_q[gi][15:0] != 16'h0000) begin
        limit = 24'(xtra_q[gi][15:0]) * 24'(CYC_PER_US);
      end else begin
        limit = 24'(DEF_FILTER_CYC);
      end
    end

    // Level follows the pin only after it has held the new value for the limit
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        level_q <= 1'b0;
        flt_cnt_q <= 24'h00_0000;
      end else if (sync_q[1] != sync_q[2]) begin
        flt_cnt_q <= flt_cnt_q;
      end else if (sync_q[2] == level_q) begin
        flt_cnt_q <= 24'h00_0000;
      end else if (flt_cnt_q >= limit - 24'h00_0001) begin
        level_q <= sync_q[2];
        flt_cnt_q <= 24'h00_0000;
      end else begin
        flt_cnt_q <= flt_cnt_q + 24'h00_0001;
      end
    end

    assign line_val[gi] = level_q ^ flip;
    assign trig_line[gi] = (fn == FN_INPUT || fn == FN_TRIGGER) && line_val[gi];
    assign trig_hit[gi] = ext_trig && (fn == FN_INPUT || fn == FN_TRIGGER) && line_val[gi] && !val_prev_q;

    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        val_prev_q <= 1'b0;
      end else begin
        val_prev_q <= line_val[gi];
      end
    end

    always_comb begin
      if (src == SRC_TRIGGER) begin
        src_val = o_trigger_active;
      end else if (src == SRC_USER) begin
        src_val = ctrl_q[gi][USER_BIT];
      end else begin
        src_val = i_exposure_active;
      end
      case (fn)
        FN_OUTPUT: out_d[gi] = src_val ^ flip;
        FN_STROBE: out_d[gi] = (strobe_q & ctrl_q[gi][STROBE_ON_BIT]) ^ flip;
        FN_PWM: out_d[gi] = pwm_level_q ^ flip;
        default: out_d[gi] = 1'b0;
      endcase
      oe_d[gi] = (fn == FN_OUTPUT || fn == FN_STROBE || fn == FN_PWM);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_line_out <= '0;
      o_line_oe <= '0;
      o_trigger <= 1'b0;
      o_trigger_active <= 1'b0;
      o_stream_stop <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      o_line_out <= out_d;
      o_line_oe <= oe_d;
      o_trigger <= trig_any;
      o_trigger_active <= ext_trig && |trig_line;
      o_stream_stop <= ext_trig;
      exp_q <= i_exposure_active;
    end
  end

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      global_q <= GLOBAL_RST;
      strobe_time_q <= STROBE_TIME_RST;
      strobe_pat_q <= STROBE_PAT_RST;
      pwm_time_q <= PWM_TIME_RST;
      pwm_ctrl_q <= PWM_CTRL_RST;
    end else if (i_wr_en) begin
      if (i_addr == GLOBAL_CTRL) begin
        global_q <= {22'h00_0000, i_wr_data[9:8], 7'h00, i_wr_data[0]};
      end else if (i_addr == STROBE_TIME) begin
        strobe_time_q <= i_wr_data;
      end else if (i_addr == STROBE_PAT) begin
        strobe_pat_q <= {12'h000, i_wr_data[19:0]};
      end else if (i_addr == PWM_TIME) begin
        pwm_time_q <= i_wr_data;
      end else if (i_addr == PWM_CTRL) begin
        pwm_ctrl_q <= {12'h000, i_wr_data[19:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Tick timebase: fractional divide, ticks 97 or 98 clocks apart
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      acc_q <= 17'h0_0000;
      tick_q <= 1'b0;
    end else if (acc_q + 17'(TICK_INC) >= 17'(TICK_MOD)) begin
      acc_q <= acc_q + 17'(TICK_INC) - 17'(TICK_MOD);
      tick_q <= 1'b1;
    end else begin
      acc_q <= acc_q + 17'(TICK_INC);
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Strobe engine
  // ----------------------------------------------------------------
  assign ref_evt = ext_trig ? trig_any : exp_start;
  assign fire = strobe_pat_q[frame_q];

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      frame_q <= 4'h0;
    end else if (ref_evt) begin
      if (frame_q >= strobe_pat_q[PAT_PERIOD_LSB +: 4]) begin
        frame_q <= 4'h0;
      end else begin
        frame_q <= frame_q + 4'h1;
      end
    end
  end

  // A reference event while a pulse is pending is dropped to keep pulses whole
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      st_cnt_q <= 16'h0000;
      strobe_q <= 1'b0;
      dur_exp_q <= 1'b0;
      seen_exp_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (ref_evt && fire) begin
            dur_exp_q <= strobe_time_q[31:16] == 16'h0000;
            seen_exp_q <= 1'b0;
            if (strobe_time_q[15:0] == 16'h0000) begin
              st_q <= ST_PULSE;
              st_cnt_q <= strobe_time_q[31:16];
              strobe_q <= 1'b1;
            end else begin
              st_q <= ST_DELAY;
              st_cnt_q <= strobe_time_q[15:0];
            end
          end
        end
        ST_DELAY: begin
          if (tick_q && st_cnt_q <= 16'h0001) begin
            st_q <= ST_PULSE;
            st_cnt_q <= strobe_time_q[31:16];
            strobe_q <= 1'b1;
          end else if (tick_q) begin
            st_cnt_q <= st_cnt_q - 16'h0001;
          end
        end
        ST_PULSE: begin
          if (i_exposure_active) begin
            seen_exp_q <= 1'b1;
          end
          if (dur_exp_q) begin
            if (seen_exp_q && !i_exposure_active) begin
              st_q <= ST_IDLE;
              strobe_q <= 1'b0;
            end
          end else if (tick_q && st_cnt_q <= 16'h0001) begin
            st_q <= ST_IDLE;
            strobe_q <= 1'b0;
          end else if (tick_q) begin
            st_cnt_q <= st_cnt_q - 16'h0001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          strobe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Single PWM source, free of exposure and trigger
  // ----------------------------------------------------------------
  assign gate_ok = !pwm_ctrl_q[GATE_EN_BIT] ||
    (line_val[pwm_ctrl_q[GATE_LINE_LSB +: 2]] == pwm_ctrl_q[GATE_LEVEL_BIT]);
  assign pwm_start = i_wr_en && i_addr == PWM_CTRL && i_wr_data[PWM_RUN_BIT];
  assign pwm_stop = i_wr_en && i_addr == PWM_CTRL && !i_wr_data[PWM_RUN_BIT];

  // Count of zero runs until stopped; gate loss freezes level and counters alike
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pw_q <= PW_IDLE;
      pw_cnt_q <= 16'h0000;
      pw_left_q <= 16'h0000;
      pwm_level_q <= 1'b0;
    end else if (pwm_start) begin
      pw_q <= PW_HIGH;
      pw_cnt_q <= pwm_time_q[15:0];
      pw_left_q <= i_wr_data[15:0];
      pwm_level_q <= 1'b1;
    end else if (pwm_stop) begin
      pw_q <= PW_IDLE;
      pwm_level_q <= 1'b0;
    end else if (pw_q != PW_IDLE && gate_ok && tick_q) begin
      if (pw_cnt_q > 16'h0001) begin
        pw_cnt_q <= pw_cnt_q - 16'h0001;
      end else if (pw_q == PW_HIGH) begin
        pw_q <= PW_LOW;
        pw_cnt_q <= pwm_time_q[31:16];
        pwm_level_q <= 1'b0;
      end else if (pw_left_q == 16'h0001) begin
        pw_q <= PW_IDLE;
      end else begin
        pw_q <= PW_HIGH;
        pw_cnt_q <= pwm_time_q[15:0];
        pw_left_q <= (pw_left_q == 16'h0000) ? 16'h0000 : pw_left_q - 16'h0001;
        pwm_level_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (i_addr == GLOBAL_CTRL) begin
      rd_d = global_q;
    end else if (i_addr == STROBE_TIME) begin
      rd_d = strobe_time_q;
    end else if (i_addr == STROBE_PAT) begin
      rd_d = strobe_pat_q;
    end else if (i_addr == LINE_STATUS) begin
      rd_d = {25'h000_0000, pw_q != PW_IDLE, st_q != ST_IDLE,
        line_val[global_q[LINE_PICK_LSB +: 2]], line_val};
    end else if (i_addr == PWM_TIME) begin
      rd_d = pwm_time_q;
    end else if (i_addr == PWM_CTRL) begin
      rd_d = {11'h000, pw_q != PW_IDLE, pwm_ctrl_q[19:0]};
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (i_addr == 16'(PIN_CTRL_BASE + i * PIN_STRIDE)) begin
          rd_d = ctrl_q[i];
        end else if (i_addr == 16'(PIN_XTRA_BASE + i * PIN_STRIDE)) begin
          rd_d = xtra_q[i];
        end
      end
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h0000_0000;
    end else if (i_rd_en) begin
      o_rd_data <= rd_d;
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] tick_gap_q;
  // Starts one below zero so the first gap after reset reads like any other
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tick_gap_q <= 8'hFF;
    end else if (tick_q) begin
      tick_gap_q <= 8'h00;
    end else begin
      tick_gap_q <= tick_gap_q + 8'h01;
    end
  end

  status_read_a: assert property ($past(i_rd_en) && $past(i_addr) == LINE_STATUS && !$past(i_sys_rst)
    |-> o_rd_data[3:0] == $past(line_val)) else $error("status read lost line levels");
  stream_stop_a: assert property ($rose(ext_trig) |=> o_stream_stop)
    else $error("streaming not stopped by trigger mode");
  trigger_out_a: assert property (trig_any |=> o_trigger ##1 (!o_trigger || $past(trig_any)))
    else $error("trigger pulse missing");
  user_drive_a: assert property (ctrl_q[2][2:0] == FN_OUTPUT && ctrl_q[2][5:4] == SRC_USER
    |=> o_line_out[2] == ($past(ctrl_q[2][USER_BIT]) ^ $past(ctrl_q[2][FLIP_BIT])) && o_line_oe[2])
    else $error("user drive level not on line");
  input_float_a: assert property (ctrl_q[3][2:0] == FN_INPUT |=> !o_line_oe[3])
    else $error("input line driven");
  strobe_delay_a: assert property (st_q == ST_DELAY && tick_q && st_cnt_q == 16'h0001
    |=> st_q == ST_PULSE && strobe_q) else $error("strobe not started after delay");
  strobe_sync_a: assert property (ctrl_q[2][2:0] == FN_STROBE && ctrl_q[3][2:0] == FN_STROBE
    && ctrl_q[2][STROBE_ON_BIT] && ctrl_q[3][STROBE_ON_BIT] && ctrl_q[2][FLIP_BIT] == ctrl_q[3][FLIP_BIT]
    |=> o_line_out[2] == o_line_out[3]) else $error("strobe lines out of step");
  pwm_hold_a: assert property (pw_q != PW_IDLE && !gate_ok && !pwm_start && !pwm_stop
    |=> $stable(pwm_level_q) && $stable(pw_cnt_q)) else $error("PWM moved while gated");
  tick_rate_a: assert property (tick_q && $past(tick_q, 2) == 1'b0
    |-> tick_gap_q <= 8'h61 && tick_gap_q >= 8'h60) else $error("tick spacing wrong");
  strobe_pat_a: assert property (st_q == ST_IDLE && ref_evt && !fire |=> st_q == ST_IDLE)
    else $error("strobe fired on masked frame");

  strobe_cov_c: cover property (st_q == ST_DELAY ##[1:1000] strobe_q);
  pwm_gate_c: cover property (pw_q == PW_HIGH && !gate_ok);
  trig_cov_c: cover property (o_trigger && o_stream_stop);
  dur_exp_c: cover property (strobe_q && dur_exp_q ##1 !strobe_q);

endmodule

//--- verif/gms_ext_dev.sv
// Model of the trigger source and strobe-driven loads on the four lines
module gms_ext_dev (
  input wire logic i_mclk,
  input wire logic i_clear,
  input wire logic [3:0] i_line_out,
  input wire logic [3:0] i_line_oe,
  input wire logic [3:0] i_drive_level,
  output logic [3:0] o_pin,
  output logic [3:0][15:0] o_high_cyc,
  output logic [3:0][7:0] o_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_q;

  // ----------------------------------------------------------------
  // Wire level: the source drives only lines the controller leaves free
  // ----------------------------------------------------------------
  assign o_pin = (i_line_oe & i_line_out) | (~i_line_oe & i_drive_level);

  // ----------------------------------------------------------------
  // Loads count pulses and high time, so width errors show as counts
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    for (int n = 0; n < 4; n++) begin
      if (i_clear) begin
        o_high_cyc[n] <= 16'h0000;
        o_rises[n] <= 8'h00;
      end else begin
        o_high_cyc[n] <= o_high_cyc[n] + 16'(o_pin[n]);
        if (o_pin[n] && !last_q[n]) begin
          o_rises[n] <= o_rises[n] + 8'h01;
        end
      end
    end
    last_q <= o_pin;
  end
endmodule

//--- verif/tb_gms_gpio_ctrl.sv
// Self-checking bench for the GPIO mode, strobe and PWM controller
module tb_gms_gpio_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import gms_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [31:0] i_wr_data = 32'h0000_0000;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_exposure_active = 1'b0;
  logic [3:0] ext_lvl = 4'h0;
  logic clr = 1'b0;
  logic [31:0] o_rd_data;
  logic [3:0] pin;
  logic [3:0] o_line_out;
  logic [3:0] o_line_oe;
  logic o_trigger;
  logic o_trigger_active;
  logic o_stream_stop;
  logic [3:0][15:0] hi;
  logic [3:0][7:0] rises;
  int error_cnt = 0;
  int samples_checked = 0;
  int trig_cnt = 0;

  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_trigger === 1'b1) trig_cnt++;

  gms_gpio_ctrl DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_line_in(pin), .o_line_out(o_line_out),
    .o_line_oe(o_line_oe), .i_exposure_active(i_exposure_active), .o_trigger(o_trigger),
    .o_trigger_active(o_trigger_active), .o_stream_stop(o_stream_stop));
  gms_ext_dev ext (.i_mclk(i_mclk), .i_clear(clr), .i_line_out(o_line_out), .i_line_oe(o_line_oe),
    .i_drive_level(ext_lvl), .o_pin(pin), .o_high_cyc(hi), .o_rises(rises));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    #1 chk(nm, exp, o_rd_data);
  endtask
  task automatic clear();
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(1);
  endtask
  task automatic frame(input int len, input int gap);
    i_exposure_active <= 1'b1;
    cyc(len);
    i_exposure_active <= 1'b0;
    cyc(gap);
  endtask
  task automatic pulse0(input int line, input int len);
    ext_lvl[line] <= 1'b1;
    cyc(len);
    ext_lvl[line] <= 1'b0;
    cyc(60);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is near 6000 cycles; the limit leaves wide margin
  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    i_sys_rst <= 1'b0;
    rdc("line0_ctrl", PIN_CTRL_BASE, 32'h0000_0002);
    rdc("line1_ctrl", 16'h1120, 32'h0000_0001);
    rdc("pattern", STROBE_PAT, 32'h0000_FFFF);
    rdc("unmapped", 16'h1200, 32'h0000_0000);
    wr(PIN_CTRL_BASE, 32'h0000_0001);
    rdc("line0_refused", PIN_CTRL_BASE, 32'h0000_0002);
    wr(16'h1134, 32'h0001_0007);
    rdc("filter_us", 16'h1134, 32'h0000_0007);
    $display("test registers done");
    wr(GLOBAL_CTRL, 32'h0000_0001);
    cyc(2);
    chk("stream_stop", 1, o_stream_stop);
    pulse0(0, 10);
    chk("short_pulse", 0, trig_cnt);
    pulse0(0, 40);
    chk("trigger", 1, trig_cnt);
    wr(16'h1130, 32'h0000_0100);
    pulse0(2, 300);
    chk("filtered", 1, trig_cnt);
    wr(16'h1120, 32'h0000_0011);
    pulse0(2, 800);
    chk("mode0_trig", 2, trig_cnt);
    chk("trig_active", 1, o_trigger_active);
    chk("trig_active_src", 1, o_line_out[1]);
    wr(GLOBAL_CTRL, 32'h0000_0200);
    wr(16'h1120, 32'h0000_0001);
    $display("test triggers done");
    wr(16'h1130, 32'h0000_0061);
    cyc(2);
    chk("user_out", 32'h0000_0004, {28'h0, o_line_out & o_line_oe & 4'h4});
    wr(16'h1130, 32'h0000_0069);
    cyc(30);
    chk("inverted", 0, o_line_out[2]);
    // Strobe left pending by the trigger test still waits for an exposure
    rdc("levels", LINE_STATUS, 32'h0000_0034);
    i_exposure_active <= 1'b1;
    cyc(3);
    chk("exposure_src", 1, o_line_out[1]);
    i_exposure_active <= 1'b0;
    cyc(300);
    $display("test outputs done");
    wr(16'h1130, 32'h0000_0083);
    wr(16'h1140, 32'h0000_0083);
    wr(STROBE_TIME, 32'h0002_0000);
    clear();
    frame(5, 400);
    chk("strobe_len", 1, hi[3] >= 16'd97 && hi[3] <= 16'd197);
    chk("strobe_pair", hi[3], hi[2]);
    wr(STROBE_TIME, 32'h0000_0000);
    clear();
    frame(60, 100);
    chk("zero_dur", 1, hi[3] >= 16'd56 && hi[3] <= 16'd63);
    wr(STROBE_TIME, 32'h0001_0000);
    wr(STROBE_PAT, 32'h0001_0001);
    clear();
    repeat (4) frame(5, 300);
    chk("pattern_fires", 2, rises[3]);
    wr(STROBE_TIME, 32'h0001_0002);
    clear();
    frame(5, 40);
    chk("strobe_waits", 0, rises[3]);
    cyc(400);
    chk("strobe_delayed", 1, rises[3]);
    $display("test strobes done");
    wr(16'h1130, 32'h0000_0004);
    wr(PWM_TIME, 32'h0001_0001);
    clear();
    wr(PWM_CTRL, 32'h0010_0003);
    frame(5, 1000);
    chk("pwm_pulses", 3, rises[2]);
    chk("pwm_high", 1, hi[2] >= 16'd195 && hi[2] <= 16'd294);
    chk("pwm_idle", 32'h0000_0004, {28'h0, o_line_oe & ~o_line_out & 4'h4});
    wr(16'h1140, 32'h0000_0000);
    clear();
    wr(PWM_CTRL, 32'h001F_0002);
    cyc(300);
    chk("pwm_gated_level", 1, o_line_out[2]);
    chk("pwm_gated_rises", 1, rises[2]);
    ext_lvl[3] <= 1'b1;
    cyc(600);
    chk("pwm_gate_open", 2, rises[2]);
    chk("pwm_gate_done", 0, o_line_out[2]);
    $display("test pwm done");
    print_verdict();
  end
endmodule
